/* tb_uri_usart.sv */
// self-checking bench of the usart register block
`timescale 1ns/1ns
`default_nettype none
module tb_uri_usart;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [2:0]  hsize = 3'h2;
	wire logic   rdy;
	wire logic   txd;
	wire logic   rxd;
	wire logic [31:0] rdata;
	logic        rdy_n;
	logic [31:0] rd_n;
	int          n_fail = 0;
	int          n_tests = 0;
	localparam logic [7:0] OFS [20] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28,
		8'h2C, 8'h30, 8'h40, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58, 8'h34, 8'h5C};
	localparam logic [7:0] RST [20] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10,
		8'hF0, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	always #10 clk = ~clk;
	always @(negedge clk) begin
		rdy_n = rdy;
		rd_n = rdata;
	end

	uri_usart dut (.sys_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(rdy), .hreadyout_o(rdy),
		.hresp_o(), .hrdata_o(rdata), .rx_i(rxd), .tx_o(txd));
	uri_peer peer (.sys_clk_i(clk), .line_i(txd), .line_o(rxd));

	// ----------------------------------------------------------------
	// bus and compare helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (rdy_n !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (rdy_n !== 1'b1);
		q = rd_n;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk($sformatf("reg %h", a), e, q);
	endtask
	task automatic wait_rx(input int k);
		for (int i = 0; i < 1000 && peer.got.size() < k; i++) @(posedge clk);
		chk("tx frames", k, 32'(peer.got.size()));
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		for (int i = 0; i < 20; i++) rc(OFS[i], {24'h0, RST[i]});
	endtask
	task automatic t_rw;
		for (int i = 6; i < 20; i++) begin
			if (i == 9) i = 12;
			wr(OFS[i], 32'h5A);
			rc(OFS[i], (i < 18) ? 32'h5A : 32'h0);
			wr(OFS[i], 32'h0);
		end
	endtask
	task automatic t_divisor_access_bit;
		wr(8'h0C, 32'h83);
		rc(8'h00, 32'h01);
		rc(8'h04, 32'h00);
		wr(8'h04, 32'hA5);
		rc(8'h04, 32'hA5);
		wr(8'h04, 32'h00);
		wr(8'h00, 32'h00);
		rc(8'h00, 32'h00);
		wr(8'h0C, 32'h03);
		rc(8'h04, 32'h00);
		wr(8'h04, 32'h30F);
		rc(8'h04, 32'h30F);
		wr(8'h04, 32'h0);
		wr(8'h08, 32'h07);
		rc(8'h08, 32'hC1);
		wr(8'h04, 32'h02);
		rc(8'h08, 32'hC2);
		wr(8'h04, 32'h0);
	endtask
	task automatic t_tx;
		wr(8'h00, 32'hA5);
		wr(8'h00, 32'h3C);
		wait_rx(2);
		chk("tx byte 0", 32'hA5, {24'h0, peer.got[0]});
		chk("tx byte 1", 32'h3C, {24'h0, peer.got[1]});
		repeat (16) @(posedge clk);
		rc(8'h14, 32'h60);
		wr(8'h30, 32'h0);
		wr(8'h00, 32'h11);
		repeat (400) @(posedge clk);
		chk("tx held", 32'h2, 32'(peer.got.size()));
		chk("tx idle", 32'h1, {31'h0, txd});
		wr(8'h30, 32'h80);
		wait_rx(3);
		chk("tx byte 2", 32'h11, {24'h0, peer.got[2]});
	endtask
	task automatic t_rx;
		peer.send(8'h96, 1'b1);
		peer.send(8'h3C, 1'b1);
		rc(8'h14, 32'h61);
		rc(8'h00, 32'h96);
		rc(8'h00, 32'h3C);
		rc(8'h14, 32'h60);
		rc(8'h00, 32'h00);
		peer.send(8'h55, 1'b0);
		peer.send(8'h66, 1'b1);
		rc(8'h14, 32'h69);
		rc(8'h00, 32'h55);
		rc(8'h14, 32'h61);
		rc(8'h00, 32'h66);
		wr(8'h0C, 32'h00);
		peer.send(8'hF3, 1'b1);
		rc(8'h00, 32'h13);
		wr(8'h0C, 32'h03);
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_rw();
		t_divisor_access_bit();
		t_tx();
		t_rx();
		conclude();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		conclude();
	end
endmodule // tb_uri_usart
`default_nettype wire

/* uri_peer.sv */
// serial peer on the line side of the usart: frame sender and receiver
`timescale 1ns/1ns
`default_nettype none
module uri_peer #(
	parameter int BIT_CLKS = 16
) (
	input  wire logic sys_clk_i, // bench clock
	input  wire logic line_i,    // from device tx
	output logic      line_o     // to device rx
);
	logic [7:0] sh;
	logic [7:0] got [$];

	initial line_o = 1'b1;

	// ----------------------------------------------------------------
	// sender: start, eight data bits, stop, then one idle bit time
	// ----------------------------------------------------------------
	task automatic send(input logic [7:0] b, input logic stp);
		logic [9:0] f;
		f = {stp, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge sys_clk_i);
			line_o <= (i < 10) ? f[i] : 1'b1;
			repeat (BIT_CLKS - 1) @(posedge sys_clk_i);
		end
	endtask

	// ----------------------------------------------------------------
	// receiver: samples mid bit, first bit into bit 0
	// ----------------------------------------------------------------
	always begin
		@(negedge line_i);
		repeat (BIT_CLKS / 2) @(posedge sys_clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge sys_clk_i);
			sh[i] = line_i;
		end
		repeat (BIT_CLKS) @(posedge sys_clk_i);
		got.push_back(sh);
	end
endmodule // uri_peer
`default_nettype wire

/* uri_pkg.sv */
// shared types of the usart register block
package uri_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} uri_line_state_t;
endpackage

/* uri_usart.sv */
// usart with ahb-lite register slave, 16-entry fifos and serial engine
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "uri_usart_regs.svh"

module uri_usart
	import uri_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic        sys_clk_i,   // 50 MHz clock
	input  wire logic        rst_i,       // async reset, active high
	input  wire logic        hsel_i,      // slave select
	input  wire logic [31:0] haddr_i,     // byte address
	input  wire logic [1:0]  htrans_i,    // transfer type
	input  wire logic        hwrite_i,    // write when high
	input  wire logic [2:0]  hsize_i,     // transfer size
	input  wire logic [31:0] hwdata_i,    // write data
	input  wire logic        hready_i,    // bus ready
	output logic             hreadyout_o, // slave ready
	output logic             hresp_o,     // always okay
	output logic      [31:0] hrdata_o,    // read data
	input  wire logic        rx_i,        // serial input pin
	output logic             tx_o         // serial output pin
);
	localparam int AW = $clog2(FIFO_DEPTH);
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic [7:0] mask_len(input logic [7:0] d, input logic [1:0] wl);
		logic [7:0] m;
		m = 8'hFF >> (3'd3 - {1'b0, wl});
		return d & m;
	endfunction

	function automatic logic par_bit(input logic [7:0] d, input logic [7:0] line_control);
		logic p;
		p = ^mask_len(d, line_control[1:0]);
		case (line_control[5:4])
			2'b00:   return ~p;
			2'b01:   return p;
			2'b10:   return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0]  line_control_r, divisor_low_r, divisor_high_r, queue_control_r;
	logic [9:0]  int_enable_r;
	logic [7:0]  handshake_control_r, scratch_pad_r, fractional_divider_r;
	logic [7:0]  oversampling_r, tx_enable_r;
	logic [7:0]  cfg_r [8];
	logic        overrun_r;
	logic        wr_pend_r, rd_pend_r;
	logic [7:0]  wr_addr_r, rd_addr_r;
	logic [31:0] hrdata_r;
	logic [31:0] rd_mux;
	logic        divisor_access_bit;
	logic        wr_fire, rd_fire, take;

	assign divisor_access_bit = line_control_r[`URI_LCR_DIVISOR_ACCESS_BIT];
	assign take = hsel_i & htrans_i[1] & hready_i;
	assign wr_fire = wr_pend_r;
	assign rd_fire = rd_pend_r;
	assign hreadyout_o = ~rd_pend_r;
	assign hresp_o = 1'b0;
	assign hrdata_o = hrdata_r;

	// fifo storage
	logic [10:0]   rxq [FIFO_DEPTH];
	logic [7:0]    txq [FIFO_DEPTH];
	logic [AW-1:0] rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
	logic [CW-1:0] rx_cnt_r, tx_cnt_r;
	logic          rx_push, rx_pop, tx_push, tx_pop, rx_clr, tx_clr;
	logic [10:0]   rx_din;
	logic [10:0]   rx_head;

	assign rx_head = rxq[rx_rp_r];
	assign rx_clr = wr_fire && wr_addr_r == `URI_OFS_IIR && hwdata_i[`URI_FCR_RXRST];
	assign tx_clr = wr_fire && wr_addr_r == `URI_OFS_IIR && hwdata_i[`URI_FCR_TXRST];
	assign rx_pop = rd_fire && rd_addr_r == `URI_OFS_DATA && !divisor_access_bit && rx_cnt_r != '0;
	assign tx_push = wr_fire && wr_addr_r == `URI_OFS_DATA && !divisor_access_bit && tx_cnt_r != DEPTH_C;

	// ----------------------------------------------------------------
	// ahb-lite slave phases
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			rd_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= take & hwrite_i;
			rd_pend_r <= take & ~hwrite_i;
			if (take) begin
				wr_addr_r <= (haddr_i[31:8] == 24'h000000) ? {haddr_i[7:2], 2'b00} : 8'hFC;
				rd_addr_r <= (haddr_i[31:8] == 24'h000000) ? {haddr_i[7:2], 2'b00} : 8'hFC;
			end
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			line_control_r       <= 8'h00;
			divisor_low_r        <= `URI_RST_DLL;
			divisor_high_r       <= 8'h00;
			int_enable_r         <= 10'h000;
			queue_control_r      <= 8'h00;
			handshake_control_r  <= 8'h00;
			scratch_pad_r        <= 8'h00;
			fractional_divider_r <= `URI_RST_FDR;
			oversampling_r       <= `URI_RST_OSR;
			tx_enable_r          <= `URI_RST_TER;
			for (int i = 0; i < 8; i++) begin
				cfg_r[i] <= 8'h00;
			end
		end else if (wr_fire) begin
			case (wr_addr_r)
				`URI_OFS_DATA: if (divisor_access_bit) divisor_low_r <= hwdata_i[7:0];
				`URI_OFS_IER: begin
					if (divisor_access_bit) divisor_high_r <= hwdata_i[7:0];
					else int_enable_r <= {hwdata_i[9:8], 4'h0, hwdata_i[3:0]};
				end
				`URI_OFS_IIR: queue_control_r <= {hwdata_i[7:6], 5'h00, hwdata_i[0]};
				`URI_OFS_LCR:  line_control_r <= hwdata_i[7:0];
				`URI_OFS_MCR:  handshake_control_r <= hwdata_i[7:0];
				`URI_OFS_SCR:  scratch_pad_r <= hwdata_i[7:0];
				`URI_OFS_FDR:  fractional_divider_r <= hwdata_i[7:0];
				`URI_OFS_OSR:  oversampling_r <= {hwdata_i[7:1], 1'b0};
				`URI_OFS_TER:  tx_enable_r <= {hwdata_i[7], 7'h00};
				`URI_OFS_ACR:  cfg_r[0] <= hwdata_i[7:0];
				`URI_OFS_ICR:  cfg_r[1] <= hwdata_i[7:0];
				`URI_OFS_HALF_DUPLEX: cfg_r[2] <= hwdata_i[7:0];
				`URI_OFS_SCI:  cfg_r[3] <= hwdata_i[7:0];
				`URI_OFS_MDC:  cfg_r[4] <= hwdata_i[7:0];
				`URI_OFS_MDA:  cfg_r[5] <= hwdata_i[7:0];
				`URI_OFS_DLY:  cfg_r[6] <= hwdata_i[7:0];
				`URI_OFS_SYNC: cfg_r[7] <= hwdata_i[7:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// status and read mux
	// ----------------------------------------------------------------
	logic [7:0] line_state, int_identity;
	logic       tx_busy, rx_err, ls_pend, rda_pend, thre_pend;

	assign rx_err = (rx_cnt_r != '0) && (rx_head[10:8] != 3'b000);
	assign line_state = {1'b0, (tx_cnt_r == '0) && !tx_busy, tx_cnt_r == '0,
		rx_cnt_r != '0 ? rx_head[10:8] : 3'b000, overrun_r, rx_cnt_r != '0};
	assign ls_pend   = int_enable_r[2] & (rx_err | overrun_r);
	assign rda_pend  = int_enable_r[0] & (rx_cnt_r != '0);
	assign thre_pend = int_enable_r[1] & (tx_cnt_r == '0);

	always_comb begin
		logic [3:0] iid;
		iid = `URI_IID_NONE;
		if (ls_pend) iid = `URI_IID_RLS;
		else if (rda_pend) iid = `URI_IID_RDA;
		else if (thre_pend) iid = `URI_IID_THRE;
		int_identity = {{2{queue_control_r[`URI_FCR_EN]}}, 2'b00, iid};
	end

	always_comb begin
		rd_mux = 32'h00000000;
		case (rd_addr_r)
			`URI_OFS_DATA: rd_mux = divisor_access_bit ? {24'h0, divisor_low_r} : {24'h0, rx_head[7:0]};
			`URI_OFS_IER:  rd_mux = divisor_access_bit ? {24'h0, divisor_high_r} : {22'h0, int_enable_r};
			`URI_OFS_IIR:  rd_mux = {24'h0, int_identity};
			`URI_OFS_LCR:  rd_mux = {24'h0, line_control_r};
			`URI_OFS_MCR:  rd_mux = {24'h0, handshake_control_r};
			`URI_OFS_LSR:  rd_mux = {24'h0, line_state};
			`URI_OFS_SCR:  rd_mux = {24'h0, scratch_pad_r};
			`URI_OFS_FDR:  rd_mux = {24'h0, fractional_divider_r};
			`URI_OFS_OSR:  rd_mux = {24'h0, oversampling_r};
			`URI_OFS_TER:  rd_mux = {24'h0, tx_enable_r};
			`URI_OFS_ACR:  rd_mux = {24'h0, cfg_r[0]};
			`URI_OFS_ICR:  rd_mux = {24'h0, cfg_r[1]};
			`URI_OFS_HALF_DUPLEX: rd_mux = {24'h0, cfg_r[2]};
			`URI_OFS_SCI:  rd_mux = {24'h0, cfg_r[3]};
			`URI_OFS_MDC:  rd_mux = {24'h0, cfg_r[4]};
			`URI_OFS_MDA:  rd_mux = {24'h0, cfg_r[5]};
			`URI_OFS_DLY:  rd_mux = {24'h0, cfg_r[6]};
			`URI_OFS_SYNC: rd_mux = {24'h0, cfg_r[7]};
			default: rd_mux = 32'h00000000;
		endcase
		if (rd_addr_r == `URI_OFS_DATA && !divisor_access_bit && rx_cnt_r == '0) rd_mux = 32'h00000000;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) hrdata_r <= 32'h00000000;
		else if (rd_fire) hrdata_r <= rd_mux;
	end

	// overrun sticks until line_state is read; a new overrun wins over the clear
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) overrun_r <= 1'b0;
		else if (rx_push && rx_cnt_r == DEPTH_C) overrun_r <= 1'b1;
		else if (rd_fire && rd_addr_r == `URI_OFS_LSR) overrun_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// fifos
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (rx_push && rx_cnt_r != DEPTH_C) rxq[rx_wp_r] <= rx_din;
		if (tx_push) txq[tx_wp_r] <= hwdata_i[7:0];
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_wp_r  <= '0;
			rx_rp_r  <= '0;
			rx_cnt_r <= '0;
		end else if (rx_clr) begin
			rx_wp_r  <= '0;
			rx_rp_r  <= '0;
			rx_cnt_r <= '0;
		end else begin
			if (rx_push && rx_cnt_r != DEPTH_C) rx_wp_r <= rx_wp_r + 1'b1;
			if (rx_pop) rx_rp_r <= rx_rp_r + 1'b1;
			rx_cnt_r <= rx_cnt_r + CW'(rx_push && rx_cnt_r != DEPTH_C) - CW'(rx_pop);
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_wp_r  <= '0;
			tx_rp_r  <= '0;
			tx_cnt_r <= '0;
		end else if (tx_clr) begin
			tx_wp_r  <= '0;
			tx_rp_r  <= '0;
			tx_cnt_r <= '0;
		end else begin
			if (tx_push) tx_wp_r <= tx_wp_r + 1'b1;
			if (tx_pop) tx_rp_r <= tx_rp_r + 1'b1;
			tx_cnt_r <= tx_cnt_r + CW'(tx_push) - CW'(tx_pop);
		end
	end

	// ----------------------------------------------------------------
	// baud tick: divisor then oversampling
	// ----------------------------------------------------------------
	logic [15:0] div_cnt_r, div_eff;
	logic        tick;
	logic [3:0]  os_last;

	assign div_eff = ({divisor_high_r, divisor_low_r} == 16'h0000) ? 16'h0001 : {divisor_high_r, divisor_low_r};
	assign tick = (div_cnt_r >= div_eff - 16'h0001);
	assign os_last = oversampling_r[7:4];

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) div_cnt_r <= 16'h0000;
		else if (tick) div_cnt_r <= 16'h0000;
		else div_cnt_r <= div_cnt_r + 16'h0001;
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	uri_line_state_t tx_st_r;
	logic [7:0] tx_sh_r;
	logic [3:0] tx_os_r;
	logic [2:0] tx_bit_r;
	logic       tx_line_r, tx_stop2_r;

	assign tx_busy = (tx_st_r != ST_IDLE);
	assign tx_pop = !tx_busy && tx_cnt_r != '0 && tx_enable_r[`URI_TER_EN] && !tx_clr;
	assign tx_o = tx_line_r & ~line_control_r[`URI_LCR_BREAK];

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_st_r    <= ST_IDLE;
			tx_sh_r    <= 8'h00;
			tx_os_r    <= 4'h0;
			tx_bit_r   <= 3'd0;
			tx_line_r  <= 1'b1;
			tx_stop2_r <= 1'b0;
		end else begin
			case (tx_st_r)
				ST_IDLE: begin
					tx_line_r <= 1'b1;
					if (tx_pop) begin
						tx_sh_r   <= mask_len(txq[tx_rp_r], line_control_r[1:0]);
						tx_st_r   <= ST_START;
						tx_os_r   <= 4'h0;
						tx_line_r <= 1'b0;
					end
				end
				ST_START, ST_DATA, ST_PARITY, ST_STOP: if (tick) begin
					tx_os_r <= tx_os_r + 4'h1;
					if (tx_os_r == os_last) begin
						tx_os_r <= 4'h0;
						case (tx_st_r)
							ST_START: begin
								tx_st_r   <= ST_DATA;
								tx_bit_r  <= 3'd0;
								tx_line_r <= tx_sh_r[0];
							end
							ST_DATA: if (tx_bit_r == {1'b0, line_control_r[1:0]} + 3'd4) begin
								tx_st_r   <= line_control_r[`URI_LCR_PAREN] ? ST_PARITY : ST_STOP;
								tx_line_r <= line_control_r[`URI_LCR_PAREN] ? par_bit(tx_sh_r, line_control_r) : 1'b1;
								tx_stop2_r <= line_control_r[`URI_LCR_STOP2];
							end else begin
								tx_bit_r  <= tx_bit_r + 3'd1;
								tx_line_r <= tx_sh_r[tx_bit_r + 3'd1];
							end
							ST_PARITY: begin
								tx_st_r   <= ST_STOP;
								tx_line_r <= 1'b1;
							end
							default: begin
								if (tx_stop2_r) tx_stop2_r <= 1'b0;
								else tx_st_r <= ST_IDLE;
							end
						endcase
					end
				end
				default: tx_st_r <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// receiver
	// ----------------------------------------------------------------
	uri_line_state_t rx_st_r;
	logic       rx_s1_r, rx_s2_r, rx_s3_r, rx_pe_r;
	logic [7:0] rx_sh_r;
	logic [3:0] rx_os_r;
	logic [2:0] rx_bit_r;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			rx_s3_r <= 1'b1;
		end else begin
			rx_s1_r <= rx_i;
			rx_s2_r <= rx_s1_r;
			rx_s3_r <= rx_s2_r;
		end
	end

	assign rx_push = (rx_st_r == ST_STOP) && tick && (rx_os_r == os_last);
	assign rx_din = {(rx_sh_r == 8'h00) && !rx_s2_r, !rx_s2_r, rx_pe_r, mask_len(rx_sh_r, line_control_r[1:0])};

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_st_r  <= ST_IDLE;
			rx_sh_r  <= 8'h00;
			rx_os_r  <= 4'h0;
			rx_bit_r <= 3'd0;
			rx_pe_r  <= 1'b0;
		end else begin
			case (rx_st_r)
				// start on a falling edge only, so a low stop bit is not taken as a new start
				ST_IDLE: if (!rx_s2_r && rx_s3_r) begin
					rx_st_r <= ST_START;
					rx_os_r <= 4'h0;
					rx_pe_r <= 1'b0;
					rx_sh_r <= 8'h00;
				end
				ST_START: if (tick) begin
					rx_os_r <= rx_os_r + 4'h1;
					if (rx_os_r == {1'b0, os_last[3:1]}) begin
						rx_os_r  <= 4'h0;
						rx_bit_r <= 3'd0;
						rx_st_r  <= rx_s2_r ? ST_IDLE : ST_DATA;
					end
				end
				ST_DATA, ST_PARITY, ST_STOP: if (tick) begin
					rx_os_r <= rx_os_r + 4'h1;
					if (rx_os_r == os_last) begin
						rx_os_r <= 4'h0;
						case (rx_st_r)
							ST_DATA: begin
								rx_sh_r[rx_bit_r] <= rx_s2_r;
								rx_bit_r <= rx_bit_r + 3'd1;
								if (rx_bit_r == {1'b0, line_control_r[1:0]} + 3'd4)
									rx_st_r <= line_control_r[`URI_LCR_PAREN] ? ST_PARITY : ST_STOP;
							end
							ST_PARITY: begin
								rx_pe_r <= rx_s2_r != par_bit(rx_sh_r, line_control_r);
								rx_st_r <= ST_STOP;
							end
							default: rx_st_r <= ST_IDLE;
						endcase
					end
				end
				default: rx_st_r <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_DIVISOR_ACCESS_BIT_DIVLOW: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(wr_fire && divisor_access_bit && wr_addr_r == `URI_OFS_DATA && !tx_clr) |=>
			(divisor_low_r == $past(hwdata_i[7:0])) && (tx_cnt_r == $past(tx_cnt_r) - CW'($past(tx_pop))))
		else $error("divisor access write leaked into transmit fifo");
	AST_RESERVED_ZERO: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(rd_fire && rd_addr_r == 8'h34) |=> (hrdata_o == 32'h00000000) && hreadyout_o)
		else $error("reserved offset read not zero");
	AST_RX_POP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(rx_pop && !rx_push && !rx_clr) |=> rx_cnt_r == $past(rx_cnt_r) - CW'(1))
		else $error("receive read did not pop");
	AST_RX_HEAD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(rd_fire && rd_addr_r == `URI_OFS_DATA && !divisor_access_bit && rx_cnt_r != '0) |=>
			hrdata_o == {24'h0, $past(rx_head[7:0])})
		else $error("receive read did not return fifo head");
	AST_TX_PUSH: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(wr_fire && !divisor_access_bit && wr_addr_r == `URI_OFS_DATA && tx_cnt_r < DEPTH_C && !tx_pop && !tx_clr) |=>
			tx_cnt_r == $past(tx_cnt_r) + CW'(1))
		else $error("transmit write did not push");
	AST_TX_GATED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$rose(tx_busy) |-> $past(tx_enable_r[7]) && $past(tx_cnt_r) != '0)
		else $error("transmitter started while disabled or empty");
	AST_TX_LSB: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(tx_st_r == ST_START && tick && tx_os_r == os_last) |=> tx_line_r == $past(tx_sh_r[0]))
		else $error("first data bit is not the least significant");
	AST_IIR_PEND: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		int_identity[0] == !(ls_pend || rda_pend || thre_pend))
		else $error("identity bit 0 disagrees with pending state");
	AST_THRE_EMPTY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(tx_cnt_r == '0 && !tx_busy) |-> line_state[6:5] == 2'b11)
		else $error("line state does not show transmitter empty");
	AST_DIV_NONZERO: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		({divisor_high_r, divisor_low_r} == 16'h0000) |-> (div_eff == 16'h0001) && tick)
		else $error("zero divisor not treated as one");
endmodule // uri_usart
`default_nettype wire

/* uri_usart_regs.svh */
// register offsets, field positions, reset values of the usart register block
`ifndef URI_USART_REGS_SVH
`define URI_USART_REGS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define URI_OFS_DATA        8'h00
`define URI_OFS_IER         8'h04
`define URI_OFS_IIR         8'h08
`define URI_OFS_LCR         8'h0C
`define URI_OFS_MCR         8'h10
`define URI_OFS_LSR         8'h14
`define URI_OFS_MSR         8'h18
`define URI_OFS_SCR         8'h1C
`define URI_OFS_ACR         8'h20
`define URI_OFS_ICR         8'h24
`define URI_OFS_FDR         8'h28
`define URI_OFS_OSR         8'h2C
`define URI_OFS_TER         8'h30
`define URI_OFS_HALF_DUPLEX        8'h40
`define URI_OFS_SCI         8'h48
`define URI_OFS_MDC         8'h4C
`define URI_OFS_MDA         8'h50
`define URI_OFS_DLY         8'h54
`define URI_OFS_SYNC        8'h58

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define URI_RST_DLL         8'h01
`define URI_RST_IIR         8'h01
`define URI_RST_FDR         8'h10
`define URI_RST_OSR         8'hF0
`define URI_RST_TER         8'h80

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define URI_LCR_DIVISOR_ACCESS_BIT        7
`define URI_LCR_BREAK       6
`define URI_LCR_PAREN       3
`define URI_LCR_STOP2       2
`define URI_TER_EN          7
`define URI_FCR_EN          0
`define URI_FCR_RXRST       1
`define URI_FCR_TXRST       2
`define URI_IID_NONE        4'h1
`define URI_IID_RLS         4'h6
`define URI_IID_RDA         4'h4
`define URI_IID_THRE        4'h2

`endif
